/* File: logic/cicr_avs_slave.sv */
// Avalon-MM slave handshake: one wait cycle, then a one-cycle answer.
// Assumes the master holds its request until waitrequest is seen low.
`timescale 1ns/100ps
`default_nettype none

module cicr_avs_slave (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire cicr_pkg::cicr_avs_req_type avs_req,
  input wire logic [31:0] rd_value,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  output logic wr_stb
);

  logic wait_ff;
  logic [31:0] rdata_ff;
  logic nxt_wait;
  logic [31:0] nxt_rdata;
  logic active;

  always_comb begin
    active = avs_req.read | avs_req.write;
    nxt_wait = 1'b1;
    nxt_rdata = rdata_ff;
    wr_stb = avs_req.write & ~wait_ff;
    if (active && wait_ff) begin
      nxt_wait = 1'b0;
      nxt_rdata = avs_req.read ? rd_value : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;

endmodule

`default_nettype wire

/* File: logic/cicr_consts.svh */
// Constants for the core interrupt control register block.
// Assumes a 32-bit Avalon-MM bus with byte addresses.
`ifndef CICR_CONSTS_SVH
`define CICR_CONSTS_SVH

`define CICR_ADDR_W 5
`define CICR_OFF_CTRL 5'h00
`define CICR_OFF_PINFLAGS 5'h04
`define CICR_OFF_OPTION 5'h08
`define CICR_OFF_STATUS 5'h0c
`define CICR_OFF_MASK 5'h10

`define CICR_BIT_GIE 7
`define CICR_BIT_PERIPHERAL_IRQ_ENABLE 6
`define CICR_BIT_TMR_IE 5
`define CICR_BIT_EXT_IE 4
`define CICR_BIT_CHG_IE 3
`define CICR_BIT_TMR_FLAG 2
`define CICR_BIT_EXT_FLAG 1
`define CICR_BIT_CHG_FLAG 0

`define CICR_ST_TMR 0
`define CICR_ST_EXT 1
`define CICR_ST_CHG 2
`define CICR_ST_TAKEN 3
`define CICR_ST_W 4

`define CICR_CTRL_RST 8'h00
`define CICR_OPTION_RST 1'b0
`define CICR_STATUS_RST 4'h0
`define CICR_MASK_RST 4'h0
`define CICR_VECTOR 16'h0004

`endif

/* File: logic/cicr_edge_detect.sv */
// Edge detector for the external interrupt pin.
// Assumes the pin is synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none

module cicr_edge_detect (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin,
  input wire logic edge_sel,
  output logic edge_evt
);

  logic prev_ff;
  logic primed_ff;
  logic nxt_prev;
  logic nxt_primed;

  always_comb begin
    nxt_prev = pin;
    nxt_primed = 1'b1;
    if (edge_sel) begin
      edge_evt = primed_ff & pin & ~prev_ff;
    end else begin
      edge_evt = primed_ff & ~pin & prev_ff;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b0;
      primed_ff <= 1'b0;
    end else if (ce) begin
      prev_ff <= nxt_prev;
      primed_ff <= nxt_primed;
    end
  end

endmodule

`default_nettype wire

/* File: logic/cicr_pkg.sv */
// Types shared by the core interrupt control register block.
// Assumes cicr_consts.svh is compiled with it.
`include "cicr_consts.svh"

package cicr_pkg;

  typedef struct packed {
    logic read;
    logic write;
    logic [`CICR_ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } cicr_avs_req_type;

  typedef struct packed {
    logic flush;
    logic push_pc;
    logic load_pc;
    logic [15:0] vector;
  } cicr_core_ctl_type;

  typedef enum logic [1:0] {
    CICR_IDLE = 2'b01,
    CICR_VECTOR = 2'b10
  } cicr_state_type;

endpackage

/* File: logic/cicr_top.sv */
// Core interrupt control register with vector sequencing and bus access.
// Assumes synchronous event pulses and a core that reports instruction
// boundaries and interrupt returns.
//
// Behaviour
// - External pin request passes to the core only while bit 4 is set.
// - Bit 1 flag sets on an external pin event or on a control write of one.
// - Bit 0 is read-only, high while any per-pin change flag is set.
// - Flags set on their events regardless of any enable bit.
// - Global enable low holds off requests; they are taken once it returns.
// - Peripheral requests reach the core only with peripheral enable set.
// - Taking an interrupt flushes, clears global enable, pushes PC, loads 0004h.
// - External pin flags rising edges when edge select is one, else falling.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "cicr_consts.svh"

module cicr_top #(
  parameter int PINS = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire cicr_pkg::cicr_avs_req_type avs_req,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  input wire logic ext_pin,
  input wire logic timer_overflow_evt,
  input wire logic [PINS-1:0] pin_change_evt,
  input wire logic periph_irq_pending,
  input wire logic core_boundary,
  input wire logic core_return,
  output logic core_irq_req,
  output cicr_pkg::cicr_core_ctl_type core_ctl,
  output logic irq
);

  generate
    if (PINS < 1 || PINS > 8) begin : g_bad_pins
      $error("PINS must be between 1 and 8");
    end
  endgenerate

  function automatic logic addr_is(
    input logic [`CICR_ADDR_W-1:0] addr,
    input logic [`CICR_ADDR_W-1:0] off
  );
    addr_is = (addr[`CICR_ADDR_W-1:2] == off[`CICR_ADDR_W-1:2]);
  endfunction

  logic wr_stb;
  logic [31:0] rd_value;
  logic ext_evt;
  logic [7:0] irq_control_reg;

  logic global_irq_enable_ff;
  logic peripheral_irq_enable_ff;
  logic timer_overflow_irq_enable_ff;
  logic ext_pin_irq_enable_ff;
  logic pin_change_irq_enable_ff;
  logic timer_overflow_flag_ff;
  logic ext_pin_irq_flag_ff;
  logic ext_edge_select_ff;
  logic [PINS-1:0] per_pin_change_flags_ff;
  logic [`CICR_ST_W-1:0] status_ff;
  logic [`CICR_ST_W-1:0] mask_ff;
  logic irq_ff;
  logic core_irq_req_ff;
  cicr_pkg::cicr_core_ctl_type core_ctl_ff;
  cicr_pkg::cicr_state_type state_ff;

  logic nxt_global_irq_enable;
  logic nxt_peripheral_irq_enable;
  logic nxt_timer_overflow_irq_enable;
  logic nxt_ext_pin_irq_enable;
  logic nxt_pin_change_irq_enable;
  logic nxt_timer_overflow_flag;
  logic nxt_ext_pin_irq_flag;
  logic nxt_ext_edge_select;
  logic [PINS-1:0] nxt_per_pin_change_flags;
  logic [`CICR_ST_W-1:0] nxt_status;
  logic [`CICR_ST_W-1:0] nxt_mask;
  logic nxt_irq;
  logic nxt_core_irq_req;
  cicr_pkg::cicr_core_ctl_type nxt_core_ctl;
  cicr_pkg::cicr_state_type nxt_state;

  logic pin_change_summary_flag;
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_pins;
  logic wr_option;
  logic wr_status;
  logic wr_mask;
  logic source_pending;
  logic take;
  logic [`CICR_ST_W-1:0] evt_vec;

  cicr_avs_slave u_avs (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .avs_req(avs_req),
    .rd_value(rd_value),
    .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata),
    .wr_stb(wr_stb)
  );

  cicr_edge_detect u_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .pin(ext_pin),
    .edge_sel(ext_edge_select_ff),
    .edge_evt(ext_evt)
  );

  // Write decode
  always_comb begin
    wr_lane0 = wr_stb & avs_req.byteenable[0];
    wr_ctrl = wr_lane0 & addr_is(avs_req.address, `CICR_OFF_CTRL);
    wr_pins = wr_lane0 & addr_is(avs_req.address, `CICR_OFF_PINFLAGS);
    wr_option = wr_lane0 & addr_is(avs_req.address, `CICR_OFF_OPTION);
    wr_status = wr_lane0 & addr_is(avs_req.address, `CICR_OFF_STATUS);
    wr_mask = wr_lane0 & addr_is(avs_req.address, `CICR_OFF_MASK);
  end

  assign pin_change_summary_flag = |per_pin_change_flags_ff;

  always_comb begin
    irq_control_reg = 8'h00;
    irq_control_reg[`CICR_BIT_GIE] = global_irq_enable_ff;
    irq_control_reg[`CICR_BIT_PERIPHERAL_IRQ_ENABLE] = peripheral_irq_enable_ff;
    irq_control_reg[`CICR_BIT_TMR_IE] = timer_overflow_irq_enable_ff;
    irq_control_reg[`CICR_BIT_EXT_IE] = ext_pin_irq_enable_ff;
    irq_control_reg[`CICR_BIT_CHG_IE] = pin_change_irq_enable_ff;
    irq_control_reg[`CICR_BIT_TMR_FLAG] = timer_overflow_flag_ff;
    irq_control_reg[`CICR_BIT_EXT_FLAG] = ext_pin_irq_flag_ff;
    irq_control_reg[`CICR_BIT_CHG_FLAG] = pin_change_summary_flag;
  end

  // Read mux, unmapped reads give zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (addr_is(avs_req.address, `CICR_OFF_CTRL)) begin
      rd_value[7:0] = irq_control_reg;
    end else if (addr_is(avs_req.address, `CICR_OFF_PINFLAGS)) begin
      rd_value[PINS-1:0] = per_pin_change_flags_ff;
    end else if (addr_is(avs_req.address, `CICR_OFF_OPTION)) begin
      rd_value[0] = ext_edge_select_ff;
    end else if (addr_is(avs_req.address, `CICR_OFF_STATUS)) begin
      rd_value[`CICR_ST_W-1:0] = status_ff;
    end else if (addr_is(avs_req.address, `CICR_OFF_MASK)) begin
      rd_value[`CICR_ST_W-1:0] = mask_ff;
    end
  end

  // Request qualification and take decision
  always_comb begin
    source_pending = 1'b0;
    if (ext_pin_irq_enable_ff && ext_pin_irq_flag_ff) begin
      source_pending = 1'b1;
    end
    if (timer_overflow_irq_enable_ff && timer_overflow_flag_ff) begin
      source_pending = 1'b1;
    end
    if (pin_change_irq_enable_ff && pin_change_summary_flag) begin
      source_pending = 1'b1;
    end
    if (peripheral_irq_enable_ff && periph_irq_pending) begin
      source_pending = 1'b1;
    end
    take = global_irq_enable_ff & source_pending & core_boundary &
           (state_ff == cicr_pkg::CICR_IDLE);
    nxt_core_irq_req = global_irq_enable_ff & source_pending;
  end

  // Control register next values
  always_comb begin
    nxt_global_irq_enable = global_irq_enable_ff;
    nxt_peripheral_irq_enable = peripheral_irq_enable_ff;
    nxt_timer_overflow_irq_enable = timer_overflow_irq_enable_ff;
    nxt_ext_pin_irq_enable = ext_pin_irq_enable_ff;
    nxt_pin_change_irq_enable = pin_change_irq_enable_ff;
    nxt_timer_overflow_flag = timer_overflow_flag_ff;
    nxt_ext_pin_irq_flag = ext_pin_irq_flag_ff;
    nxt_ext_edge_select = ext_edge_select_ff;
    if (wr_ctrl) begin
      nxt_global_irq_enable = avs_req.writedata[`CICR_BIT_GIE];
      nxt_peripheral_irq_enable = avs_req.writedata[`CICR_BIT_PERIPHERAL_IRQ_ENABLE];
      nxt_timer_overflow_irq_enable = avs_req.writedata[`CICR_BIT_TMR_IE];
      nxt_ext_pin_irq_enable = avs_req.writedata[`CICR_BIT_EXT_IE];
      nxt_pin_change_irq_enable = avs_req.writedata[`CICR_BIT_CHG_IE];
      nxt_timer_overflow_flag = avs_req.writedata[`CICR_BIT_TMR_FLAG];
      nxt_ext_pin_irq_flag = avs_req.writedata[`CICR_BIT_EXT_FLAG];
    end
    if (wr_option) begin
      nxt_ext_edge_select = avs_req.writedata[0];
    end
    if (timer_overflow_evt) begin
      nxt_timer_overflow_flag = 1'b1;
    end
    if (ext_evt) begin
      nxt_ext_pin_irq_flag = 1'b1;
    end
    if (core_return) begin
      nxt_global_irq_enable = 1'b1;
    end
    if (take) begin
      nxt_global_irq_enable = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      global_irq_enable_ff <= 1'(`CICR_CTRL_RST >> `CICR_BIT_GIE);
      peripheral_irq_enable_ff <= 1'b0;
      timer_overflow_irq_enable_ff <= 1'b0;
      ext_pin_irq_enable_ff <= 1'b0;
      pin_change_irq_enable_ff <= 1'b0;
      timer_overflow_flag_ff <= 1'b0;
      ext_pin_irq_flag_ff <= 1'b0;
      ext_edge_select_ff <= `CICR_OPTION_RST;
    end else if (ce) begin
      global_irq_enable_ff <= nxt_global_irq_enable;
      peripheral_irq_enable_ff <= nxt_peripheral_irq_enable;
      timer_overflow_irq_enable_ff <= nxt_timer_overflow_irq_enable;
      ext_pin_irq_enable_ff <= nxt_ext_pin_irq_enable;
      pin_change_irq_enable_ff <= nxt_pin_change_irq_enable;
      timer_overflow_flag_ff <= nxt_timer_overflow_flag;
      ext_pin_irq_flag_ff <= nxt_ext_pin_irq_flag;
      ext_edge_select_ff <= nxt_ext_edge_select;
    end
  end

  // Per-pin change flags, software clears by writing zero
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      always_comb begin
        nxt_per_pin_change_flags[gi] = per_pin_change_flags_ff[gi];
        if (wr_pins && !avs_req.writedata[gi]) begin
          nxt_per_pin_change_flags[gi] = 1'b0;
        end
        if (pin_change_evt[gi]) begin
          nxt_per_pin_change_flags[gi] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per_pin_change_flags_ff <= '0;
    end else if (ce) begin
      per_pin_change_flags_ff <= nxt_per_pin_change_flags;
    end
  end

  // Sticky status, mask and interrupt line
  always_comb begin
    evt_vec = '0;
    evt_vec[`CICR_ST_TMR] = timer_overflow_evt;
    evt_vec[`CICR_ST_EXT] = ext_evt;
    evt_vec[`CICR_ST_CHG] = |pin_change_evt;
    evt_vec[`CICR_ST_TAKEN] = take;
    nxt_status = status_ff;
    nxt_mask = mask_ff;
    if (wr_status) begin
      nxt_status = status_ff & ~avs_req.writedata[`CICR_ST_W-1:0];
    end
    if (wr_mask) begin
      nxt_mask = avs_req.writedata[`CICR_ST_W-1:0];
    end
    nxt_status = nxt_status | evt_vec;
    nxt_irq = |(status_ff & mask_ff);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_ff <= `CICR_STATUS_RST;
      mask_ff <= `CICR_MASK_RST;
      irq_ff <= 1'b0;
    end else if (ce) begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
    end
  end

  // Vector sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_core_ctl = '0;
    case (state_ff)
      cicr_pkg::CICR_IDLE: begin
        if (take) begin
          nxt_core_ctl.flush = 1'b1;
          nxt_core_ctl.push_pc = 1'b1;
          nxt_state = cicr_pkg::CICR_VECTOR;
        end
      end
      cicr_pkg::CICR_VECTOR: begin
        nxt_core_ctl.load_pc = 1'b1;
        nxt_core_ctl.vector = `CICR_VECTOR;
        nxt_state = cicr_pkg::CICR_IDLE;
      end
      default: begin
        nxt_state = cicr_pkg::CICR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= cicr_pkg::CICR_IDLE;
      core_ctl_ff <= '0;
      core_irq_req_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      core_ctl_ff <= nxt_core_ctl;
      core_irq_req_ff <= nxt_core_irq_req;
    end
  end

  assign core_ctl = core_ctl_ff;
  assign core_irq_req = core_irq_req_ff;
  assign irq = irq_ff;

endmodule

`default_nettype wire

/* File: testbench/cicr_core_model.sv */
// Processor core model: offers boundaries, returns from service, counts vectors.
// Assumes the bench commands boundaries and returns.
`timescale 1ns/100ps
`default_nettype none

module cicr_core_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic accept_en,
  input wire logic ret_cmd,
  input wire cicr_pkg::cicr_core_ctl_type core_ctl,
  output logic core_boundary,
  output logic core_return,
  output int take_count,
  output logic seq_bad_ff
);
  logic flushed_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_boundary <= 1'b0;
      core_return <= 1'b0;
      take_count <= 0;
      flushed_ff <= 1'b0;
      seq_bad_ff <= 1'b0;
    end else begin
      core_boundary <= accept_en;
      core_return <= ret_cmd;
      flushed_ff <= core_ctl.flush;
      if (core_ctl.load_pc) begin
        take_count <= take_count + 1;
        if (!flushed_ff || core_ctl.vector !== 16'h0004) begin
          seq_bad_ff <= 1'b1;
        end
      end
    end
  end
endmodule

`default_nettype wire

/* File: testbench/cicr_properties.sv */
// Checker for the interrupt control block, bus and vector outputs.
// Assumes it is bound to cicr_top and sees its ports only.
`timescale 1ns/100ps
`default_nettype none

module cicr_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire cicr_pkg::cicr_avs_req_type avs_req,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic core_return,
  input wire cicr_pkg::cicr_core_ctl_type core_ctl
);
  logic req;
  assign req = avs_req.read | avs_req.write;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wait_one_a: assert property (ce && req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer missing after one wait cycle");
  wait_short_a: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  answer_asked_a: assert property ($fell(avs_waitrequest) |-> $past(req))
    else $error("bus answer without a request");
  upper_zero_a: assert property (!avs_waitrequest && avs_req.read |->
    avs_readdata[31:8] == 24'h000000) else $error("upper read bytes not zero");
  flush_push_a: assert property (core_ctl.flush |-> core_ctl.push_pc)
    else $error("flush without push");
  vector_load_a: assert property (ce && core_ctl.flush |=> core_ctl.load_pc &&
    core_ctl.vector == 16'h0004) else $error("vector load missing after flush");
  flush_once_a: assert property (ce && core_ctl.flush |=> !core_ctl.flush)
    else $error("flush longer than one cycle");
  vector_zero_a: assert property (!core_ctl.load_pc |-> core_ctl.vector == 16'h0000)
    else $error("vector not zero outside load");
  no_retake_a: assert property (ce && core_ctl.load_pc && !core_return &&
    !$past(core_return) |=> !core_ctl.flush) else $error("taken with global enable off");
  cover property (!avs_waitrequest && avs_req.read);
  cover property (!avs_waitrequest && avs_req.write);
  cover property (core_ctl.load_pc);
endmodule

bind cicr_top cicr_properties cicr_properties_inst (.sys_clk(sys_clk), .rst(rst), .ce(ce),
  .avs_req(avs_req), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .core_return(core_return), .core_ctl(core_ctl));

`default_nettype wire

/* File: testbench/cicr_tb_top.sv */
// Self-checking bench for the interrupt control block.
// Assumes the design package and the core model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module cicr_tb_top;
  logic sys_clk, rst, ce, ext_pin, timer_overflow_evt, periph_irq_pending;
  logic accept_en, ret_cmd, avs_waitrequest, core_irq_req, irq;
  logic core_boundary, core_return, seq_bad_ff;
  logic [7:0] pin_change_evt;
  logic [31:0] avs_readdata, rd;
  cicr_pkg::cicr_avs_req_type avs_req;
  cicr_pkg::cicr_core_ctl_type core_ctl;
  int take_count, miscompares, num_checks;

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  cicr_top #(.PINS(8)) cicr_top_inst (.sys_clk, .rst, .ce, .avs_req, .avs_waitrequest,
    .avs_readdata, .ext_pin, .timer_overflow_evt, .pin_change_evt, .periph_irq_pending,
    .core_boundary, .core_return, .core_irq_req, .core_ctl, .irq);
  cicr_core_model cicr_core_model_inst (.sys_clk, .rst, .accept_en, .ret_cmd, .core_ctl,
    .core_boundary, .core_return, .take_count, .seq_bad_ff);

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    avs_req <= '{!wr, wr, a, 4'hf, {24'h000000, d}};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) miscompares++;
    rd = avs_readdata;
    avs_req <= '0;
  endtask

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task pulse_timer;
    @(posedge sys_clk) timer_overflow_evt <= 1'b1;
    @(posedge sys_clk) timer_overflow_evt <= 1'b0;
  endtask

  task wait_take(input int k);
    int n;
    n = 0;
    while (take_count < k && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    check("take count", take_count, k);
  endtask

  task t_reset;
    logic [4:0] offs [6];
    offs = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14};
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, offs[i], 8'h00);
      check("reset value", rd, 32'h0);
    end
    $display("test reset done");
  endtask

  task t_access;
    bus(1'b1, 5'h00, 8'h7f);
    bus(1'b0, 5'h00, 8'h00);
    check("control rw", rd, 32'h7e);
    bus(1'b1, 5'h14, 8'hff);
    bus(1'b0, 5'h14, 8'h00);
    check("unmapped", rd, 32'h0);
    bus(1'b1, 5'h00, 8'h00);
    $display("test access done");
  endtask

  task t_flags;
    bus(1'b1, 5'h08, 8'h01);
    @(posedge sys_clk) ext_pin <= 1'b1;
    pulse_timer;
    bus(1'b0, 5'h00, 8'h00);
    check("flags no enable", rd, 32'h06);
    bus(1'b1, 5'h00, 8'h00);
    @(posedge sys_clk) ext_pin <= 1'b0;
    bus(1'b0, 5'h00, 8'h00);
    check("falling ignored", rd, 32'h0);
    bus(1'b1, 5'h08, 8'h00);
    @(posedge sys_clk) ext_pin <= 1'b1;
    bus(1'b0, 5'h00, 8'h00);
    check("rising ignored", rd, 32'h0);
    @(posedge sys_clk) ext_pin <= 1'b0;
    bus(1'b0, 5'h00, 8'h00);
    check("falling taken", rd, 32'h02);
    $display("test flags done");
  endtask

  task t_change;
    @(posedge sys_clk) pin_change_evt <= 8'h08;
    @(posedge sys_clk) pin_change_evt <= 8'h00;
    bus(1'b0, 5'h04, 8'h00);
    check("pin flags", rd, 32'h08);
    bus(1'b1, 5'h00, 8'h00);
    bus(1'b0, 5'h00, 8'h00);
    check("summary read only", rd, 32'h01);
    bus(1'b1, 5'h04, 8'h00);
    bus(1'b0, 5'h00, 8'h00);
    check("summary clear", rd, 32'h0);
    $display("test change done");
  endtask

  task t_freeze;
    @(posedge sys_clk) ce <= 1'b0;
    pulse_timer;
    @(posedge sys_clk) ce <= 1'b1;
    bus(1'b0, 5'h00, 8'h00);
    check("frozen timer flag", rd, 32'h0);
    pulse_timer;
    bus(1'b0, 5'h00, 8'h00);
    check("running timer flag", rd, 32'h04);
    bus(1'b1, 5'h00, 8'h00);
    $display("test freeze done");
  endtask

  task t_irq;
    bus(1'b1, 5'h0c, 8'h0f);
    pulse_timer;
    bus(1'b0, 5'h0c, 8'h00);
    check("status timer", rd, 32'h01);
    check("irq masked", irq, 32'h0);
    bus(1'b1, 5'h10, 8'h01);
    tick(2);
    check("irq unmasked", irq, 32'h1);
    bus(1'b1, 5'h0c, 8'h01);
    tick(2);
    check("irq cleared", irq, 32'h0);
    bus(1'b1, 5'h10, 8'h00);
    $display("test irq done");
  endtask

  task t_take;
    accept_en <= 1'b1;
    periph_irq_pending <= 1'b1;
    bus(1'b1, 5'h00, 8'h82);
    tick(8);
    check("blocked takes", take_count, 0);
    check("blocked request", core_irq_req, 32'h0);
    accept_en <= 1'b0;
    bus(1'b1, 5'h00, 8'hc0);
    tick(2);
    check("request no boundary", core_irq_req, 32'h1);
    check("no boundary no take", take_count, 0);
    accept_en <= 1'b1;
    wait_take(1);
    bus(1'b0, 5'h00, 8'h00);
    check("global cleared", rd, 32'h40);
    periph_irq_pending <= 1'b0;
    bus(1'b1, 5'h00, 8'h12);
    tick(8);
    check("held off", take_count, 1);
    check("request held off", core_irq_req, 32'h0);
    @(posedge sys_clk) ret_cmd <= 1'b1;
    @(posedge sys_clk) ret_cmd <= 1'b0;
    wait_take(2);
    check("vector sequence", seq_bad_ff, 32'h0);
    bus(1'b0, 5'h0c, 8'h00);
    check("taken status", rd[3], 32'h1);
    $display("test take done");
  endtask

  task end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    end_sim;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    avs_req = '0;
    ext_pin = 1'b0;
    timer_overflow_evt = 1'b0;
    pin_change_evt = 8'h00;
    periph_irq_pending = 1'b0;
    accept_en = 1'b0;
    ret_cmd = 1'b0;
    miscompares = 0;
    num_checks = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_access;
    t_flags;
    t_change;
    t_freeze;
    t_irq;
    t_take;
    end_sim;
  end
endmodule

`default_nettype wire
